// ==== core/acmp_pkg.sv ====
// Constants shared by the comparator control block and its helpers
`default_nettype none
package acmp_pkg;
   // Register bus geometry
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   localparam int CHAN_W = 3;
   localparam int EVT_W  = 2;

   // Register offsets
   localparam logic [2:0] OFS_CMP_CSR  = 3'h0;
   localparam logic [2:0] OFS_CONV_CSB = 3'h1;
   localparam logic [2:0] OFS_IRQ_STAT = 3'h2;
   localparam logic [2:0] OFS_IRQ_CLR  = 3'h3;
   localparam logic [2:0] OFS_IRQ_EN   = 3'h4;

   // Comparator control/status field positions
   localparam int CSR_DISABLE  = 7;
   localparam int CSR_BANDGAP  = 6;
   localparam int CSR_OUTPUT   = 5;
   localparam int CSR_FLAG     = 4;
   localparam int CSR_IRQ_EN   = 3;
   localparam int CSR_CAPTURE  = 2;
   localparam int CSR_EVT_HI   = 1;
   localparam int CSR_EVT_LO   = 0;

   // Converter control/status B field positions
   localparam int CSB_MUX_EN   = 6;
   localparam int CSB_TRIG_HI  = 2;
   localparam int CSB_TRIG_LO  = 0;

   // Interrupt status bit positions
   localparam int IRQ_MATCH    = 0;
   localparam int IRQ_TOGGLE   = 1;
   localparam int IRQ_W        = 2;

   // Reset values
   localparam logic [7:0] RST_CMP_CSR  = 8'h00;
   localparam logic [7:0] RST_CONV_CSB = 8'h00;
   localparam logic [1:0] RST_IRQ      = 2'h0;

   // Event select encodings
   localparam logic [1:0] EVT_TOGGLE   = 2'h0;
   localparam logic [1:0] EVT_RESERVED = 2'h1;
   localparam logic [1:0] EVT_FALL     = 2'h2;
   localparam logic [1:0] EVT_RISE     = 2'h3;

   // Synchroniser depth and post-reset settle count
   localparam int SYNC_STAGES = 2;
   localparam logic [1:0] SETTLE_CYC = 2'h3;
endpackage : acmp_pkg
`default_nettype wire

// ==== core/acmp_sync2.sv ====
// Two-stage level synchroniser for the asynchronous comparator result
`default_nettype none
module acmp_sync2
(
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic d_async,
   output var  logic q
);
   logic meta_r;

   // First stage is read only by the second stage
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         meta_r <= 1'b0;
         q      <= 1'b0;
      end
      else
      begin
         meta_r <= d_async;
         q      <= meta_r;
      end
   end
endmodule : acmp_sync2
`default_nettype wire

// ==== core/acmp_edge_detect.sv ====
// Edge detector and event-mode matcher on the synchronised comparator output
`default_nettype none
module acmp_edge_detect
(
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       level,
   input  wire logic [1:0] mode,
   output logic            fire,
   output logic            toggled
);
   logic prev_r;
   logic rise;
   logic fall;

   // Previous sample of the synchronised output
   always_ff @(posedge core_clk)
   begin
      if (rst)
         prev_r <= 1'b0;
      else
         prev_r <= level;
   end

   // One sample pair gives one event, so a level change fires once
   assign rise    = level & ~prev_r;
   assign fall    = ~level & prev_r;
   assign toggled = rise | fall;

   // Mode match; the reserved code never fires
   assign fire = ((mode == acmp_pkg::EVT_TOGGLE) & toggled)
               | ((mode == acmp_pkg::EVT_FALL) & fall)
               | ((mode == acmp_pkg::EVT_RISE) & rise);
endmodule : acmp_edge_detect
`default_nettype wire

// ==== core/analog_comparator_control.sv ====
// Digital control, status and interrupt logic around the analog comparator
`default_nettype none
module analog_comparator_control
(
   input  wire logic       core_clk,
   input  wire logic       rst,
   // Register port
   input  wire logic [2:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output var  logic [7:0] reg_rdata,
   // Analog comparator macro
   input  wire logic       cmp_raw_async,
   output var  logic       cmp_power_down,
   output var  logic       cmp_pos_bandgap,
   output var  logic       cmp_neg_from_mux,
   output var  logic [2:0] cmp_neg_channel,
   // Converter state and CPU interrupt side
   input  wire logic       conv_enable,
   input  wire logic [2:0] conv_channel_field,
   input  wire logic       global_irq_enable,
   input  wire logic       cmp_irq_ack,
   output var  logic       cmp_irq_req,
   output var  logic       irq,
   // Timer capture front end, converter trigger select and comparator output status
   output var  logic       capture_input,
   output var  logic [2:0] conv_trigger_sel,
   output var  logic       cmp_output_status
);
   logic [7:0] csr_r;
   logic [7:0] csr_nxt;
   logic       mux_en_r;
   logic [2:0] trig_r;
   logic [1:0] stat_r;
   logic [1:0] stat_nxt;
   logic [1:0] en_r;
   logic       flag_nxt;
   logic       cmp_sync;
   logic       fire;
   logic       toggled;
   logic       flag_clr;
   logic [1:0] events;
   logic [7:0] rd_mux;
   logic [1:0] settle_r;

   // Address decode
   wire sel_csr  = (reg_addr == acmp_pkg::OFS_CMP_CSR);
   wire sel_csb  = (reg_addr == acmp_pkg::OFS_CONV_CSB);
   wire sel_stat = (reg_addr == acmp_pkg::OFS_IRQ_STAT);
   wire sel_clr  = (reg_addr == acmp_pkg::OFS_IRQ_CLR);
   wire sel_en   = (reg_addr == acmp_pkg::OFS_IRQ_EN);
   wire wr_csr   = reg_wr & sel_csr;
   wire wr_csb   = reg_wr & sel_csb;
   wire wr_clr   = reg_wr & sel_clr;
   wire wr_en    = reg_wr & sel_en;

   // Field views of the control register
   wire flag      = csr_r[acmp_pkg::CSR_FLAG];
   wire irq_en    = csr_r[acmp_pkg::CSR_IRQ_EN];
   wire [1:0] evt = csr_r[acmp_pkg::CSR_EVT_HI:acmp_pkg::CSR_EVT_LO];

   // Raw result is asynchronous to core_clk; synchronise first
   acmp_sync2 u_sync
   (
      .core_clk (core_clk),
      .rst      (rst),
      .d_async  (cmp_raw_async),
      .q        (cmp_sync)
   );

   // Event matching on synchronised samples
   acmp_edge_detect u_edge
   (
      .core_clk (core_clk),
      .rst      (rst),
      .level    (cmp_sync),
      .mode     (evt),
      .fire     (fire),
      .toggled  (toggled)
   );

   // Status output follows the synchronised comparator result
   assign cmp_output_status = cmp_sync;

   // Flag: hardware set wins over vector or write-one clear
   assign flag_clr = cmp_irq_ack | (wr_csr & reg_wdata[acmp_pkg::CSR_FLAG]);
   assign flag_nxt = fire | (flag & ~flag_clr);

   // Control register next value; output bit is never stored
   assign csr_nxt = wr_csr
                  ? {reg_wdata[7:6], 1'b0, flag_nxt, reg_wdata[3:0]}
                  : {csr_r[7:6], 1'b0, flag_nxt, csr_r[3:0]};

   // Sticky system interrupt status, set wins over clear
   assign events   = {toggled, fire};
   assign stat_nxt = events | (stat_r & ~(wr_clr ? reg_wdata[1:0] : 2'h0));

   // Read multiplexer; unmapped offsets and the clear register read zero
   assign rd_mux = sel_csr  ? {csr_r[7:6], cmp_sync, csr_r[4:0]} :
                   sel_csb  ? {1'b0, mux_en_r, 3'h0, trig_r} :
                   sel_stat ? {6'h00, stat_r} :
                   sel_en   ? {6'h00, en_r} :
                   8'h00;

   // Comparator control register
   always_ff @(posedge core_clk)
   begin
      if (rst)
         csr_r <= acmp_pkg::RST_CMP_CSR;
      else
         csr_r <= csr_nxt;
   end

   // Converter register B: mux enable resets to zero
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         mux_en_r <= acmp_pkg::RST_CONV_CSB[acmp_pkg::CSB_MUX_EN];
         trig_r   <= acmp_pkg::RST_CONV_CSB[2:0];
      end
      else if (wr_csb)
      begin
         mux_en_r <= reg_wdata[acmp_pkg::CSB_MUX_EN];
         trig_r   <= reg_wdata[acmp_pkg::CSB_TRIG_HI:acmp_pkg::CSB_TRIG_LO];
      end
   end

   // Interrupt status and enable registers
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         stat_r <= acmp_pkg::RST_IRQ;
         en_r   <= acmp_pkg::RST_IRQ;
      end
      else
      begin
         stat_r <= stat_nxt;
         if (wr_en)
            en_r <= reg_wdata[1:0];
      end
   end

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge core_clk)
   begin
      if (rst)
         reg_rdata <= 8'h00;
      else if (reg_rd)
         reg_rdata <= rd_mux;
      else
         reg_rdata <= 8'h00;
   end

   // Registered drives to the analog macro, timer and converter
   // Input selection changes are not glitch-free for the comparator;
   // software masks the interrupt around them
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         cmp_power_down   <= 1'b0;
         cmp_pos_bandgap  <= 1'b0;
         cmp_neg_from_mux <= 1'b0;
         cmp_neg_channel  <= 3'h0;
         capture_input    <= 1'b0;
         conv_trigger_sel <= 3'h0;
      end
      else
      begin
         cmp_power_down   <= csr_r[acmp_pkg::CSR_DISABLE];
         cmp_pos_bandgap  <= csr_r[acmp_pkg::CSR_BANDGAP];
         cmp_neg_from_mux <= mux_en_r & ~conv_enable;
         cmp_neg_channel  <= conv_channel_field;
         capture_input    <= csr_r[acmp_pkg::CSR_CAPTURE] & cmp_sync;
         conv_trigger_sel <= trig_r;
      end
   end

   // Interrupt outputs; the timer side gates capture interrupts itself
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         cmp_irq_req <= 1'b0;
         irq         <= 1'b0;
      end
      else
      begin
         cmp_irq_req <= flag & irq_en & global_irq_enable;
         irq         <= |(stat_r & en_r);
      end
   end

   // Cycles since reset, for checks that look back past the synchroniser
   always_ff @(posedge core_clk)
   begin
      if (rst)
         settle_r <= 2'h0;
      else if (settle_r != acmp_pkg::SETTLE_CYC)
         settle_r <= settle_r + 2'h1;
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   property p_sync_latency;
      (settle_r == acmp_pkg::SETTLE_CYC) |-> (cmp_sync == $past(cmp_raw_async, 2));
   endproperty
   a_sync_latency: assert property (p_sync_latency)
      else $error("status bit does not follow raw result by two cycles");

   property p_read_output;
      reg_rd && sel_csr |=> (reg_rdata[acmp_pkg::CSR_OUTPUT] == $past(cmp_sync));
   endproperty
   a_read_output: assert property (p_read_output)
      else $error("read of output bit does not match synchronised result");

   property p_rise_sets;
      (evt == acmp_pkg::EVT_RISE) && cmp_sync && !$past(cmp_sync) |=> flag;
   endproperty
   a_rise_sets: assert property (p_rise_sets)
      else $error("rising edge in rise mode did not set flag");

   property p_fall_sets;
      (evt == acmp_pkg::EVT_FALL) && !cmp_sync && $past(cmp_sync) |=> flag;
   endproperty
   a_fall_sets: assert property (p_fall_sets)
      else $error("falling edge in fall mode did not set flag");

   // Watches the flag itself, so a broken mode decode cannot hide behind fire
   property p_reserved_quiet;
      (evt == acmp_pkg::EVT_RESERVED) && !flag |=> !flag;
   endproperty
   a_reserved_quiet: assert property (p_reserved_quiet)
      else $error("reserved mode produced an event");

   property p_flag_only_by_event;
      !flag ##1 flag |-> $past(fire);
   endproperty
   a_flag_only_by_event: assert property (p_flag_only_by_event)
      else $error("flag set without a matching event");

   property p_ack_clears;
      flag && cmp_irq_ack && !fire |=> !flag;
   endproperty
   a_ack_clears: assert property (p_ack_clears)
      else $error("vector acknowledge did not clear flag");

   property p_w1c_clears;
      flag && wr_csr && reg_wdata[acmp_pkg::CSR_FLAG] && !fire |=> !flag;
   endproperty
   a_w1c_clears: assert property (p_w1c_clears)
      else $error("write one did not clear flag");

   property p_req_gate;
      cmp_irq_req |-> $past(flag) && $past(irq_en) && $past(global_irq_enable);
   endproperty
   a_req_gate: assert property (p_req_gate)
      else $error("interrupt request without flag and both enables");

   property p_power_down;
      wr_csr ##1 1'b1 |=> (cmp_power_down == $past(reg_wdata[acmp_pkg::CSR_DISABLE], 2));
   endproperty
   a_power_down: assert property (p_power_down)
      else $error("power down does not follow disable bit");

   property p_bandgap;
      ##1 (cmp_pos_bandgap == $past(csr_r[acmp_pkg::CSR_BANDGAP]));
   endproperty
   a_bandgap: assert property (p_bandgap)
      else $error("bandgap select not driven from register");

   property p_capture;
      capture_input |-> $past(csr_r[acmp_pkg::CSR_CAPTURE]) && $past(cmp_sync);
   endproperty
   a_capture: assert property (p_capture)
      else $error("capture input active without route or output");

   property p_neg_mux;
      ##1 (cmp_neg_from_mux == ($past(mux_en_r) && !$past(conv_enable)));
   endproperty
   a_neg_mux: assert property (p_neg_mux)
      else $error("negative input source selected wrongly");

   property p_mux_reset;
      @(posedge core_clk) disable iff (1'b0) rst |=> !mux_en_r;
   endproperty
   a_mux_reset: assert property (p_mux_reset)
      else $error("mux enable not zero after reset");

   c_rise_irq: cover property (flag && irq_en && global_irq_enable ##1 cmp_irq_req);
   c_ack: cover property (flag ##1 cmp_irq_ack ##1 !flag);
   c_set_and_clear: cover property (fire && flag_clr);
   c_mux_path: cover property (cmp_neg_from_mux && capture_input);
endmodule : analog_comparator_control
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench for the comparator control block, register port and event flags
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;

`define CHK(got, exp) \
   begin \
      n_compared++; \
      if ((got) !== (exp)) \
      begin \
         n_fail++; \
         $display("Error at %0t: got %h expected %h", $time, got, exp); \
      end \
   end

   logic       core_clk, rst;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic       reg_wr, reg_rd;
   logic       cmp_raw_async, cmp_power_down, cmp_pos_bandgap, cmp_neg_from_mux;
   logic [2:0] cmp_neg_channel, conv_channel_field, conv_trigger_sel;
   logic       conv_enable, global_irq_enable, cmp_irq_ack, cmp_irq_req, irq;
   logic       capture_input, cmp_output_status;
   int         n_fail, n_compared;
   logic [7:0] exp_q[$];
   logic [7:0] exp_v, d;
   logic [2:0] ch;
   logic [1:0] mode;
   logic       rd_pend, e_rise, e_fall;

   analog_comparator_control DUT
   (
      .core_clk           (core_clk),
      .rst                (rst),
      .reg_addr           (reg_addr),
      .reg_wdata          (reg_wdata),
      .reg_wr             (reg_wr),
      .reg_rd             (reg_rd),
      .reg_rdata          (reg_rdata),
      .cmp_raw_async      (cmp_raw_async),
      .cmp_power_down     (cmp_power_down),
      .cmp_pos_bandgap    (cmp_pos_bandgap),
      .cmp_neg_from_mux   (cmp_neg_from_mux),
      .cmp_neg_channel    (cmp_neg_channel),
      .conv_enable        (conv_enable),
      .conv_channel_field (conv_channel_field),
      .global_irq_enable  (global_irq_enable),
      .cmp_irq_ack        (cmp_irq_ack),
      .cmp_irq_req        (cmp_irq_req),
      .irq                (irq),
      .capture_input      (capture_input),
      .conv_trigger_sel   (conv_trigger_sel),
      .cmp_output_status  (cmp_output_status)
   );

   // 250 MHz clock
   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   // Wait whole cycles, then step clear of the edge so registered outputs have landed
   task tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick

   task wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
   endtask : wr

   // The expectation is queued when the read is issued; the monitor pairs it with the data
   task rd(input logic [2:0] a, input logic [7:0] v);
      @(posedge core_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      exp_q.push_back(v);
      @(posedge core_clk);
      reg_rd   <= 1'b0;
   endtask : rd

   // Read data stand only in the cycle after the strobe, so look mid-cycle there
   always @(posedge core_clk) rd_pend = reg_rd;
   always @(negedge core_clk)
   begin
      if (rd_pend && exp_q.size() > 0)
      begin
         exp_v = exp_q.pop_front();
         `CHK(reg_rdata, exp_v)
      end
   end

   task give_verdict;
      $display("Compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : give_verdict

   // Whole run is a few hundred cycles; give it ample margin
   initial
   begin
      #80000;
      n_fail++;
      give_verdict;
   end

   initial
   begin
      {rst, reg_wr, reg_rd, reg_addr, reg_wdata, cmp_raw_async} = {1'b1, 14'h0};
      {conv_enable, conv_channel_field, global_irq_enable, cmp_irq_ack} = 6'h00;
      n_fail = 0;
      n_compared = 0;
      void'($urandom(64573));
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      // Reset values and an unmapped offset
      rd(acmp_pkg::OFS_CMP_CSR, 8'h00);
      rd(acmp_pkg::OFS_CONV_CSB, 8'h00);
      rd(3'h6, 8'h00);
      // Power and bandgap select follow the control register
      d = 8'($urandom()) & 8'hCC;
      wr(acmp_pkg::OFS_CMP_CSR, d);
      tick(2);
      `CHK(cmp_power_down, d[7])
      `CHK(cmp_pos_bandgap, d[6])
      rd(acmp_pkg::OFS_CMP_CSR, d);
      wr(acmp_pkg::OFS_CMP_CSR, 8'h00);
      // Negative input selection over mux enable and converter enable
      // Converter power reduction is taken as cleared before the mux is used
      for (int i = 0; i < 4; i++)
      begin
         d  = (8'($urandom()) & 8'hBF) | (i[1] ? 8'h40 : 8'h00);
         ch = 3'($urandom());
         wr(acmp_pkg::OFS_CONV_CSB, d);
         conv_enable        <= i[0];
         conv_channel_field <= ch;
         rd(acmp_pkg::OFS_CONV_CSB, d & 8'h47);
         tick(3);
         `CHK(cmp_neg_from_mux, i[1] & ~i[0])
         `CHK(cmp_neg_channel, ch)
         `CHK(conv_trigger_sel, d[2:0])
      end
      // Every event mode: one rising and one falling output edge each
      for (int m = 0; m < 4; m++)
      begin
         mode   = 2'(m);
         e_rise = (mode == acmp_pkg::EVT_TOGGLE) || (mode == acmp_pkg::EVT_RISE);
         e_fall = (mode == acmp_pkg::EVT_TOGGLE) || (mode == acmp_pkg::EVT_FALL);
         // Interrupt enable stays off while the mode changes; the same write clears the flag
         wr(acmp_pkg::OFS_CMP_CSR, {6'h04, mode});
         cmp_raw_async <= 1'b1;
         tick(4);
         `CHK(cmp_output_status, 1'b1)
         tick(2);
         rd(acmp_pkg::OFS_CMP_CSR, {2'b00, 1'b1, e_rise, 2'b00, mode});
         wr(acmp_pkg::OFS_CMP_CSR, {6'h04, mode});
         cmp_raw_async <= 1'b0;
         tick(6);
         `CHK(cmp_output_status, 1'b0)
         rd(acmp_pkg::OFS_CMP_CSR, {3'b000, e_fall, 2'b00, mode});
         wr(acmp_pkg::OFS_CMP_CSR, {6'h04, mode});
      end
      // Capture route follows the output only while enabled
      // The timer side owns its capture interrupt enable; only the route is seen
      wr(acmp_pkg::OFS_CMP_CSR, 8'h17);
      cmp_raw_async <= 1'b1;
      tick(6);
      `CHK(capture_input, 1'b1)
      wr(acmp_pkg::OFS_CMP_CSR, 8'h13);
      tick(2);
      `CHK(capture_input, 1'b0)
      @(posedge core_clk);
      cmp_raw_async <= 1'b0;
      tick(6);
      // Rising mode with interrupt enable: request gated by the global enable
      wr(acmp_pkg::OFS_CMP_CSR, 8'h1B);
      wr(acmp_pkg::OFS_IRQ_CLR, 8'h03);
      global_irq_enable <= 1'b1;
      cmp_raw_async     <= 1'b1;
      tick(7);
      `CHK(cmp_irq_req, 1'b1)
      @(posedge core_clk);
      global_irq_enable <= 1'b0;
      tick(2);
      `CHK(cmp_irq_req, 1'b0)
      @(posedge core_clk);
      global_irq_enable <= 1'b1;
      tick(2);
      `CHK(cmp_irq_req, 1'b1)
      // Vector execution clears the flag
      @(posedge core_clk);
      cmp_irq_ack <= 1'b1;
      @(posedge core_clk);
      cmp_irq_ack <= 1'b0;
      tick(2);
      `CHK(cmp_irq_req, 1'b0)
      rd(acmp_pkg::OFS_CMP_CSR, 8'h2B);
      // Sticky status, enable mask and write-one clear
      rd(acmp_pkg::OFS_IRQ_STAT, 8'h03);
      wr(acmp_pkg::OFS_IRQ_EN, 8'h01);
      tick(2);
      `CHK(irq, 1'b1)
      wr(acmp_pkg::OFS_IRQ_EN, 8'h00);
      tick(2);
      `CHK(irq, 1'b0)
      wr(acmp_pkg::OFS_IRQ_CLR, 8'h03);
      rd(acmp_pkg::OFS_IRQ_STAT, 8'h00);
      cmp_raw_async <= 1'b0;
      tick(6);
      // A falling edge is a toggle but no match in rising mode
      rd(acmp_pkg::OFS_IRQ_STAT, 8'h02);
      wr(acmp_pkg::OFS_IRQ_EN, 8'h02);
      tick(2);
      `CHK(irq, 1'b1)
      wr(acmp_pkg::OFS_IRQ_CLR, 8'h02);
      tick(3);
      `CHK(irq, 1'b0)
      tick(2);
      give_verdict;
   end
endmodule : tb
`default_nettype wire
